// ### rtl/conv_clock_divider.sv
// Purpose: Converter clock enable from the internal source or a prescaler.
// Assumes: Select 0 picks the internal 2 MHz rate, 1..7 pick sys/2..sys/128.
// Notes: Counters rest while the converter is off to save power.
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider #(
   parameter int OSC_DIV = 63,
   parameter int PRESCALE_BITS = 7
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic [2:0] clockSelect,
   output logic tick
);
   localparam int OW = $clog2(OSC_DIV);
   logic [PRESCALE_BITS-1:0] prescale_reg;
   logic [OW-1:0] osc_reg;
   logic [PRESCALE_BITS-1:0] mask;

   // Tap mask of the prescaler, independent of any CPU clock divider
   assign mask = PRESCALE_BITS'((32'h1 << clockSelect) - 32'h1);

   // Both dividers run together so a select change needs no restart
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prescale_reg <= '0;
         osc_reg <= '0;
         tick <= 1'b0;
      end else if (!enable) begin
         prescale_reg <= '0;
         osc_reg <= '0;
         tick <= 1'b0;
      end else begin
         prescale_reg <= prescale_reg + PRESCALE_BITS'(1);
         osc_reg <= (osc_reg == OW'(OSC_DIV - 1)) ? '0 : osc_reg + OW'(1);
         if (clockSelect == 3'h0) begin
            tick <= (osc_reg == OW'(OSC_DIV - 1));
         end else begin
            tick <= ((prescale_reg & mask) == mask);
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/sar_converter_control.sv
// Purpose: Control for a 10-bit SAR converter working as ADC or DAC.
// Assumes: Analog comparator and DAC core sit outside; register port is plain.
// Notes: Mode and data are latched at the start of each conversion.
// Notes on behaviour
// - Signed 10-bit results, sign-extended or left-zeroed
// - Data registers read-only ADC, write-only DAC
// - Differential select picks pin pair difference
// - Eight single-ended or four differential inputs
// - Inputs connect only while connect bit set
// - Converter powered only while enabled
// - ADC takes 13 cycles, samples in third
// - ADC end writes result, sets done flag
// - Result holds until next conversion completes
// - DAC mode needs enable and DAC select
// - DAC ignores mux bits, forces output pins
// - DAC takes 11 cycles, output at seven
// - DAC end sets done flag, same delay
// - DAC buffer loads at start, holds throughout
// - Default converter clock from internal oscillator
// - Alternative clock from 7-bit system prescaler
// - ADC clock choice independent of CPU divider
// - Start bit launches conversion, clears at end
// - Selected timer overflow launches conversion
// - Interrupt vectoring clears done flag
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sar_converter_control import sar_converter_pkg::*; #(
   parameter int OSC_DIV = OSC_DIV_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] address,
   input wire logic [7:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [7:0] readData,
   input wire logic [2:0] timerOverflow,
   input wire logic intAck,
   input wire logic compareHigh,
   output logic doneFlag,
   output logic converterPower,
   output logic oscRun,
   output logic muxConnect,
   output logic [2:0] muxChannel,
   output logic muxDifferential,
   output logic sampleActive,
   output logic [9:0] sarCode,
   output logic [9:0] dacOutput,
   output logic p2InputOnly
);
   logic enable_reg;
   logic dacSel_reg;
   logic result_left_adjust_reg;
   logic [2:0] clkSel_reg;
   logic connect_reg;
   logic differential_select_reg;
   logic [2:0] chan_reg;
   logic [1:0] trig_reg;
   logic busy_reg;
   logic convDac_reg;
   logic [3:0] cycleCount_reg;
   logic pendingDone_reg;
   logic [9:0] result_reg;
   logic [9:0] dacBuffer_reg;
   logic [7:0] dacHigh_reg;
   logic [7:0] dacLow_reg;
   logic tick;
   logic wrCtrl;
   logic wrInsel;
   logic trigHit;
   logic swStart;
   logic startAccept;
   logic startDac;
   logic convEnd;
   logic abort;
   logic [3:0] adcBit;
   logic [3:0] dacBit;
   logic [9:0] dacWord;
   logic [7:0] readNext;

   conv_clock_divider #(
      .OSC_DIV(OSC_DIV),
      .PRESCALE_BITS(PRESCALE_BITS)
   ) u_div (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .enable(enable_reg),
      .clockSelect(clkSel_reg),
      .tick(tick)
   );

   // Decode of register writes
   assign wrCtrl = writeStrobe && (address == CTRL_ADDR);
   assign wrInsel = writeStrobe && (address == INSEL_ADDR);

   // Timer trigger; code 0 means software start only
   always_comb begin
      case (trig_reg)
         2'h1: trigHit = timerOverflow[0];
         2'h2: trigHit = timerOverflow[1];
         2'h3: trigHit = timerOverflow[2];
         default: trigHit = 1'b0;
      endcase
   end

   // Start needs enable in the same write; running conversions win
   assign swStart = wrCtrl && writeData[CTRL_START_BIT] && writeData[CTRL_ENABLE_BIT];
   assign startAccept = !busy_reg && (swStart || (enable_reg && trigHit));
   assign startDac = wrCtrl ? writeData[CTRL_DAC_BIT] : dacSel_reg; // Mode as now written
   assign abort = busy_reg && !enable_reg;
   assign convEnd = busy_reg && tick &&
      (cycleCount_reg == (convDac_reg ? DAC_CYCLES : ADC_CYCLES));

   // Bit resolved in the current cycle, MSB first
   assign adcBit = ADC_CYCLES - cycleCount_reg;
   assign dacBit = DAC_CYCLES - cycleCount_reg;

   // DAC word from the data pair, laid out like a result
   assign dacWord = result_left_adjust_reg ? {dacHigh_reg, dacLow_reg[7:6]} :
      {dacHigh_reg[1:0], dacLow_reg};

   // Configuration bits; a software start does not stick, busy shows it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dacSel_reg <= CTRL_RESET[CTRL_DAC_BIT];
         enable_reg <= CTRL_RESET[CTRL_ENABLE_BIT];
         result_left_adjust_reg <= CTRL_RESET[CTRL_RESULT_LEFT_ADJUST_BIT];
         clkSel_reg <= CTRL_RESET[CTRL_CLK_LSB +: 3];
         connect_reg <= INSEL_RESET[INSEL_CONNECT_BIT];
         trig_reg <= INSEL_RESET[INSEL_TRIG_LSB +: 2];
         differential_select_reg <= INSEL_RESET[INSEL_DIFFERENTIAL_SELECT_BIT];
         chan_reg <= INSEL_RESET[INSEL_CHAN_LSB +: 3];
      end else begin
         if (wrCtrl) begin
            dacSel_reg <= writeData[CTRL_DAC_BIT];
            enable_reg <= writeData[CTRL_ENABLE_BIT];
            result_left_adjust_reg <= writeData[CTRL_RESULT_LEFT_ADJUST_BIT];
            clkSel_reg <= writeData[CTRL_CLK_LSB +: 3];
         end
         if (wrInsel) begin
            connect_reg <= writeData[INSEL_CONNECT_BIT];
            trig_reg <= writeData[INSEL_TRIG_LSB +: 2];
            differential_select_reg <= writeData[INSEL_DIFFERENTIAL_SELECT_BIT];
            chan_reg <= writeData[INSEL_CHAN_LSB +: 3];
         end
      end
   end

   // Busy and cycle count; disabling the converter aborts the conversion
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy_reg <= 1'b0;
         convDac_reg <= 1'b0;
         cycleCount_reg <= 4'h1;
      end else if (startAccept) begin
         busy_reg <= 1'b1;
         convDac_reg <= startDac;
         cycleCount_reg <= 4'h1;
      end else if (convEnd || abort) begin
         busy_reg <= 1'b0;
      end else if (busy_reg && tick) begin
         cycleCount_reg <= cycleCount_reg + 4'h1;
      end
   end

   // Sample window covers exactly the third converter cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sampleActive <= 1'b0;
      end else if (!busy_reg || convDac_reg || abort) begin
         sampleActive <= 1'b0;
      end else if (tick) begin
         sampleActive <= (cycleCount_reg == SAMPLE_CYCLE - 4'h1);
      end
   end

   // Successive approximation; ADC judges bits in cycles 4..13
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sarCode <= MIDSCALE;
         result_reg <= '0;
      end else if (busy_reg && tick && !convDac_reg) begin
         if (cycleCount_reg == SAMPLE_CYCLE) begin
            sarCode <= MIDSCALE;
         end else if (cycleCount_reg > SAMPLE_CYCLE) begin
            sarCode[adcBit] <= compareHigh;
            if (adcBit != 4'h0) begin
               sarCode[adcBit - 4'h1] <= 1'b1;
            end
         end
         // Offset code to two's complement; held until the next end
         if (convEnd) begin
            result_reg <= {sarCode[9:1], compareHigh} ^ MIDSCALE;
         end
      end else if (busy_reg && tick && convDac_reg && cycleCount_reg > 4'h1) begin
         // DAC builds from cycle two onward, MSB first
         sarCode[dacBit] <= dacBuffer_reg[dacBit];
      end
   end

   // Data pair is write-only and only in DAC mode; buffer taken at start
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dacHigh_reg <= '0;
         dacLow_reg <= '0;
         dacBuffer_reg <= MIDSCALE;
      end else begin
         if (writeStrobe && dacSel_reg && address == HIGH_ADDR) begin
            dacHigh_reg <= writeData;
         end
         if (writeStrobe && dacSel_reg && address == LOW_ADDR) begin
            dacLow_reg <= writeData;
         end
         if (startAccept && startDac) begin
            dacBuffer_reg <= dacWord ^ MIDSCALE;
         end
      end
   end

   // Analog output follows the buffer once five MSBs are resolved
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dacOutput <= MIDSCALE;
      end else if (busy_reg && tick && convDac_reg &&
            cycleCount_reg == DAC_SHOW_CYCLE - 4'h1) begin
         dacOutput <= dacBuffer_reg;
      end
   end

   // Done flag waits one converter clock after the end; set wins over clear
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pendingDone_reg <= 1'b0;
         doneFlag <= CTRL_RESET[CTRL_DONE_BIT];
      end else begin
         if (intAck || (wrCtrl && !writeData[CTRL_DONE_BIT])) begin
            doneFlag <= 1'b0;
         end
         if (convEnd) begin
            pendingDone_reg <= 1'b1;
         end else if (pendingDone_reg && tick) begin
            pendingDone_reg <= 1'b0;
            doneFlag <= 1'b1;
         end
      end
   end

   // Pin controls, registered; the mux is gated off in DAC mode
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         converterPower <= 1'b0;
         oscRun <= 1'b0;
         muxConnect <= 1'b0;
         muxChannel <= '0;
         muxDifferential <= 1'b0;
         p2InputOnly <= 1'b0;
      end else begin
         converterPower <= enable_reg;
         oscRun <= enable_reg && (clkSel_reg == 3'h0);
         muxConnect <= enable_reg && !dacSel_reg && connect_reg;
         muxChannel <= differential_select_reg ? {1'b0, chan_reg[1:0]} : chan_reg;
         muxDifferential <= differential_select_reg && !dacSel_reg;
         p2InputOnly <= enable_reg && dacSel_reg;
      end
   end

   // Read mux; results show only in ADC mode, unmapped reads give zero
   always_comb begin
      readNext = 8'h00;
      case (address)
         CTRL_ADDR: readNext = {doneFlag, busy_reg, dacSel_reg, enable_reg,
            result_left_adjust_reg, clkSel_reg};
         INSEL_ADDR: readNext = {connect_reg, 1'b0, trig_reg, differential_select_reg, chan_reg};
         HIGH_ADDR: begin
            if (!dacSel_reg) begin
               readNext = result_left_adjust_reg ? result_reg[9:2] :
                  {{PAD_BITS{result_reg[9]}}, result_reg[9:8]};
            end
         end
         LOW_ADDR: begin
            if (!dacSel_reg) begin
               readNext = result_left_adjust_reg ? {result_reg[1:0], {PAD_BITS{1'b0}}} :
                  result_reg[7:0];
            end
         end
         default: readNext = 8'h00;
      endcase
   end

   // Read data stands for the one cycle after the strobe
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         readData <= 8'h00;
      end else begin
         readData <= readStrobe ? readNext : 8'h00;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_endTick;
      convEnd;
   endsequence

   sequence s_adcRead(logic [7:0] a);
      readStrobe && address == a && !dacSel_reg;
   endsequence

   a_left_zeroed: assert property (
      s_adcRead(LOW_ADDR) and result_left_adjust_reg |=> readData[5:0] == 6'h00)
      else $error("left-adjusted low byte has nonzero pad");

   a_sign_extend: assert property (
      s_adcRead(HIGH_ADDR) and !result_left_adjust_reg |=> readData[7:2] == {6{result_reg[9]}})
      else $error("right-adjusted high byte not sign extended");

   a_dac_unreadable: assert property (
      readStrobe && dacSel_reg && (address == LOW_ADDR || address == HIGH_ADDR)
      |=> readData == 8'h00)
      else $error("data pair readable in DAC mode");

   a_power_gated: assert property (
      !enable_reg ##1 !enable_reg |-> !converterPower)
      else $error("converter powered while disabled");

   a_sample_window: assert property (
      sampleActive |-> busy_reg && !convDac_reg && cycleCount_reg == SAMPLE_CYCLE)
      else $error("sample outside third cycle");

   a_end_done: assert property (
      s_endTick ##1 (!tick)[*1] ##0 pendingDone_reg |-> !busy_reg)
      else $error("busy still set after conversion end");

   a_done_delay: assert property (
      pendingDone_reg && tick && !convEnd |=> doneFlag && !pendingDone_reg)
      else $error("done flag not set one converter clock after end");

   a_result_hold: assert property (
      !convEnd |=> $stable(result_reg))
      else $error("result changed without a conversion end");

   a_start_ignored: assert property (
      busy_reg && !tick && !abort |=> $stable(cycleCount_reg) && $stable(convDac_reg))
      else $error("start accepted while busy");

   a_buffer_hold: assert property (
      busy_reg && convDac_reg |=> $stable(dacBuffer_reg))
      else $error("DAC buffer changed during conversion");

   a_mux_gated: assert property (
      muxConnect |-> $past(connect_reg) && $past(enable_reg) && !$past(dacSel_reg))
      else $error("inputs connected without connect bit");

   a_ack_clears: assert property (
      intAck && !(pendingDone_reg && tick) |=> !doneFlag)
      else $error("done flag survived interrupt vectoring");

   a_p2_forced: assert property (
      enable_reg && dacSel_reg |=> p2InputOnly)
      else $error("DAC pins not forced to input-only");
endmodule
`default_nettype wire

// ### rtl/sar_converter_pkg.sv
// Purpose: Shared constants for the successive-approximation converter control.
// Assumes: 8-bit register port, one 125 MHz system clock.
// Notes: Converter clock is a one-cycle enable pulse, not a clock.
package sar_converter_pkg;
   // Register addresses
   localparam logic [7:0] CTRL_ADDR = 8'hD9;
   localparam logic [7:0] INSEL_ADDR = 8'hDA;
   localparam logic [7:0] LOW_ADDR = 8'hDC;
   localparam logic [7:0] HIGH_ADDR = 8'hDD;
   // Control register fields
   localparam int CTRL_DONE_BIT = 7;
   localparam int CTRL_START_BIT = 6;
   localparam int CTRL_DAC_BIT = 5;
   localparam int CTRL_ENABLE_BIT = 4;
   localparam int CTRL_RESULT_LEFT_ADJUST_BIT = 3;
   localparam int CTRL_CLK_LSB = 0;
   // Input-select register fields
   localparam int INSEL_CONNECT_BIT = 7;
   localparam int INSEL_TRIG_LSB = 4;
   localparam int INSEL_DIFFERENTIAL_SELECT_BIT = 3;
   localparam int INSEL_CHAN_LSB = 0;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] INSEL_RESET = 8'h00;
   // Result layout
   localparam int RESULT_BITS = 10;
   localparam int PAD_BITS = 6;
   localparam logic [9:0] MIDSCALE = 10'h200;
   // Conversion sequencing, in converter clock cycles
   localparam logic [3:0] ADC_CYCLES = 4'hD;
   localparam logic [3:0] DAC_CYCLES = 4'hB;
   localparam logic [3:0] SAMPLE_CYCLE = 4'h3;
   localparam logic [3:0] DAC_SHOW_CYCLE = 4'h7;
   // Internal converter clock: system clock/63, no faster than the target
   localparam int SYS_CLK_HZ = 125_000_000;
   localparam int CONV_CLK_HZ = 2_000_000;
   localparam int OSC_DIV_CYCLES = (SYS_CLK_HZ + CONV_CLK_HZ - 1) / CONV_CLK_HZ;
   localparam int PRESCALE_BITS = 7;
endpackage

// ### verification/analog_core_model.sv
// Purpose: Behavioural analog side: input mux, sample-and-hold, comparator.
// Assumes: Pin levels are offset-binary codes; pair p uses pins 2p and 2p+1.
// Notes: A disconnected mux samples junk so a gating fault shows up.
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [9:0] level [8], // Pins are only sensed, never driven
   input wire logic muxConnect,
   input wire logic [2:0] muxChannel,
   input wire logic muxDifferential,
   input wire logic sampleActive,
   input wire logic [9:0] sarCode,
   output logic compareHigh
);
   logic [9:0] heldCode;
   logic [9:0] seenCode;

   // Mux: single pin about midscale, or pin pair difference
   always_comb begin
      if (muxDifferential) begin
         seenCode = 10'h200 + level[{muxChannel[1:0], 1'b0}] - level[{muxChannel[1:0], 1'b1}];
      end else begin
         seenCode = level[muxChannel];
      end
      if (!muxConnect) begin
         seenCode = ~heldCode;
      end
   end

   // Hold capacitor follows the input only while sampling
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         heldCode <= 10'h000;
      end else if (sampleActive) begin
         heldCode <= seenCode;
      end
   end

   // Comparator against the trial code
   assign compareHigh = (heldCode >= sarCode);
endmodule
`default_nettype wire

// ### verification/test_sar_converter_control.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: Divider shortened to 4 cycles so conversions stay brief.
// Notes: Timing per cycle is guarded by the design's own assertions.
`timescale 1ns/1ps
`default_nettype none
module test_sar_converter_control;
   import sar_converter_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] address = 8'h00;
   logic [7:0] writeData = 8'h00;
   logic writeStrobe = 1'b0;
   logic readStrobe = 1'b0;
   logic [7:0] readData;
   logic [2:0] timerOverflow = 3'h0;
   logic intAck = 1'b0;
   logic compareHigh;
   logic doneFlag, converterPower, oscRun, muxConnect, muxDifferential;
   logic sampleActive, p2InputOnly;
   logic [2:0] muxChannel;
   logic [9:0] sarCode, dacOutput;
   logic [9:0] level [8];
   int nErrors = 0;
   int checks = 0;
   int t0;

   // 125 MHz system clock
   always #4 clk_sys = ~clk_sys;

   sar_converter_control #(.OSC_DIV(4)) DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .address(address),
      .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
      .readData(readData), .timerOverflow(timerOverflow), .intAck(intAck),
      .compareHigh(compareHigh), .doneFlag(doneFlag), .converterPower(converterPower),
      .oscRun(oscRun), .muxConnect(muxConnect), .muxChannel(muxChannel),
      .muxDifferential(muxDifferential), .sampleActive(sampleActive), .sarCode(sarCode),
      .dacOutput(dacOutput), .p2InputOnly(p2InputOnly)
   );

   analog_core_model analog (
      .clk_sys(clk_sys), .reset_n(reset_n), .level(level), .muxConnect(muxConnect),
      .muxChannel(muxChannel), .muxDifferential(muxDifferential),
      .sampleActive(sampleActive), .sarCode(sarCode), .compareHigh(compareHigh)
   );

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, nErrors);
      if (nErrors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         nErrors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bus cycles: one-cycle strobes launched right after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clk_sys);
      writeStrobe <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clk_sys);
      readStrobe <= 1'b0;
      #1 chk({8'h00, readData}, {8'h00, exp});
   endtask

   // Bounded wait for the done flag; n counts cycles waited
   task automatic waitDone(output int n);
      n = 0;
      while (doneFlag !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         #1 n++;
      end
      chk({15'h0, doneFlag}, 16'h0001);
   endtask

   task automatic clearFlag();
      @(posedge clk_sys);
      intAck <= 1'b1;
      @(posedge clk_sys);
      intAck <= 1'b0;
      #1 chk({15'h0, doneFlag}, 16'h0000);
   endtask

   task automatic pulseTimer(input logic [2:0] which);
      @(posedge clk_sys);
      timerOverflow <= which;
      @(posedge clk_sys);
      timerOverflow <= 3'h0;
   endtask

   task automatic testReset();
      rd(CTRL_ADDR, CTRL_RESET);
      rd(INSEL_ADDR, INSEL_RESET);
      rd(8'h55, 8'h00);
      chk({15'h0, converterPower}, 16'h0000);
      chk({6'h0, sarCode}, 16'h0200);
      $display("test reset done");
   endtask

   task automatic testAdcRight();
      wr(INSEL_ADDR, 8'h85);
      wr(CTRL_ADDR, 8'h50);
      waitDone(t0);
      chk({15'h0, t0 >= 52 && t0 <= 60}, 16'h0001);
      rd(CTRL_ADDR, 8'h90);
      rd(HIGH_ADDR, 8'hFE);
      rd(LOW_ADDR, 8'hA7);
      chk({12'h0, oscRun, converterPower, muxConnect, muxDifferential}, 16'h000E);
      chk({13'h0, muxChannel}, 16'h0005);
      wr(LOW_ADDR, 8'h00);
      rd(LOW_ADDR, 8'hA7);
      clearFlag();
      $display("test adc right done");
   endtask

   // A second start in mid-run must not restart the sequence
   task automatic testAdcLeftBusy();
      int n;
      wr(CTRL_ADDR, 8'h58);
      repeat (20) @(posedge clk_sys);
      wr(CTRL_ADDR, 8'h58);
      waitDone(n);
      chk({15'h0, n <= t0 - 10}, 16'h0001);
      rd(HIGH_ADDR, 8'hA9);
      rd(LOW_ADDR, 8'hC0);
      clearFlag();
      $display("test adc left done");
   endtask

   task automatic testTimerDiff();
      int n;
      wr(INSEL_ADDR, 8'h05);
      wr(INSEL_ADDR, 8'h29);
      wr(INSEL_ADDR, 8'hA9);
      wr(CTRL_ADDR, 8'h1B);
      pulseTimer(3'b001);
      rd(CTRL_ADDR, 8'h1B);
      pulseTimer(3'b010);
      rd(CTRL_ADDR, 8'h5B);
      chk({12'h0, muxDifferential, muxChannel}, 16'h0009);
      waitDone(n);
      rd(HIGH_ADDR, 8'h50);
      rd(LOW_ADDR, 8'hC0);
      clearFlag();
      $display("test timer differential done");
   endtask

   // Buffer is taken at start; a later data write must not leak out
   task automatic testDac();
      int n;
      wr(CTRL_ADDR, 8'h30); // Internal rate, below the CPU clock
      repeat (2) @(posedge clk_sys);
      #1 chk({13'h0, p2InputOnly, muxConnect, muxDifferential}, 16'h0004);
      wr(HIGH_ADDR, 8'h00);
      wr(LOW_ADDR, 8'hC5);
      rd(LOW_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h70);
      repeat (3) @(posedge clk_sys);
      #1 chk({6'h0, dacOutput}, 16'h0200);
      wr(LOW_ADDR, 8'h11);
      waitDone(n);
      chk({6'h0, dacOutput}, 16'h02C5);
      rd(CTRL_ADDR, 8'hB0);
      $display("test dac done");
   endtask

   task automatic testPowerOff();
      wr(CTRL_ADDR, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1 chk({13'h0, converterPower, oscRun, p2InputOnly}, 16'h0000);
      rd(CTRL_ADDR, 8'h00);
      $display("test power off done");
   endtask

   // Main sequence
   initial begin
      level[0] = 10'h100;
      level[1] = 10'h3F0;
      level[2] = 10'h2C3;
      level[3] = 10'h180;
      level[4] = 10'h010;
      level[5] = 10'h0A7;
      level[6] = 10'h333;
      level[7] = 10'h1FF;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      testReset();
      testAdcRight();
      testAdcLeftBusy();
      testTimerDiff();
      testDac();
      testPowerOff();
      conclude();
   end

   // Watchdog: whole run needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      nErrors++;
      conclude();
   end
endmodule
`default_nettype wire
